// ==== hw/nco_cfg.svh ====
// constants of the numerically controlled oscillator and its serial word port
// How it works
// - reset control bit holds phase accumulator zero
// - clear bit zeroes resample enable and source
// - resample and bit selection need explicit write
// - reset bit leaves frequency and phase words
// - output starts six cycles after reset release
// - frequency is clock times word over 2^32
// - phase shift is offset word times 2pi/4096
// - selection source switchable at run time
// - shift clock may run or idle either level
// - data sampled on shift clock falling edges
// - MSB first; command, address, data fields
// - frequency pin keys between two frequency words
// - four selectable phase offset words
// - source bit 0 pins, 1 internal bits
// - word transfers only after sixteenth falling edge
// - resample adds two clock cycles of latency
// - D12 reset, D11 clear; clear self-returns
`ifndef NCO_CFG_SVH
`define NCO_CFG_SVH

// ****************************************
// widths and counts
// ****************************************
`define NCO_ACC_W 32
`define NCO_PH_W 12
`define NCO_WORD_W 16
`define NCO_WORD_BITS 5'h10
`define NCO_LAST_BIT 5'h0F
`define NCO_RUN_LAT 6
`define NCO_SYNC_LAT 2

// ****************************************
// command word layout
// ****************************************
`define NCO_CTRL_SYNCSEL 2'h2
`define NCO_CTRL_PWRCLR 2'h3
`define NCO_CMD_DEST 4'h3
`define NCO_CMD_SELBITS 4'h1
`define NCO_BIT_SYNC 13
`define NCO_BIT_SELECT_SOURCE_BIT 12
`define NCO_BIT_SLEEP 13
`define NCO_BIT_RESET 12
`define NCO_BIT_CLR 11
`define NCO_BIT_FSEL 11
`define NCO_BIT_PSEL_HI 10
`define NCO_BIT_PSEL_LO 9

// ****************************************
// register port map
// ****************************************
`define NCO_ADDR_W 8
`define NCO_REG_STATUS 8'h00
`define NCO_REG_PHASE 8'h04
`define NCO_REG_CMD 8'h08
`define NCO_ST_RESET 0
`define NCO_ST_SLEEP 1
`define NCO_ST_SYNC 2
`define NCO_ST_SELECT_SOURCE_BIT 3
`define NCO_ST_FSEL 4
`define NCO_ST_PSEL 5
`define NCO_ST_BITCNT 7

`endif

// ==== hw/nco_pkg.sv ====
// types shared by the oscillator control logic
`include "nco_cfg.svh"

package nco_pkg;

  typedef struct packed
  {
    logic valid;
    logic [`NCO_WORD_W-1:0] word;
  } load_t;

  typedef struct packed
  {
    logic fsel;
    logic [1:0] psel;
  } sel_t;

  typedef struct packed
  {
    logic sclkPrev;
    logic [4:0] bitCnt;
    logic [`NCO_WORD_W-1:0] shiftReg;
    load_t ld0;
    load_t ld1;
    sel_t selPipe0;
    sel_t selPipe1;
    sel_t selBits;
    logic sync;
    logic select_source_bit;
    logic resetBit;
    logic sleep;
    logic clr;
    logic [1:0][`NCO_ACC_W-1:0] freq;
    logic [3:0][`NCO_PH_W-1:0] phase;
    logic [`NCO_ACC_W-1:0] acc;
    logic [`NCO_RUN_LAT-1:0] runPipe;
    logic [`NCO_RUN_LAT-1:0][`NCO_PH_W-1:0] addrPipe;
    logic [31:0] rdData;
  } nco_state_t;

endpackage

// ==== hw/nco_serial_load_and_init.sv ====
// oscillator control: serial word port, select logic, phase accumulator
`timescale 1ns/10ps
`include "nco_cfg.svh"

module nco_serial_load_and_init
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [`NCO_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic word_frame_n,
  input wire logic serialShiftClock,
  input wire logic serial_data_in,
  input wire logic frequency_register_select,
  input wire logic phase_register_select_lo,
  input wire logic phase_register_select_hi,
  output logic [`NCO_PH_W-1:0] waveAddr,
  output logic waveActive,
  output logic sleepMode
);

  nco_pkg::nco_state_t st_q;
  nco_pkg::nco_state_t st_d;

  logic sclkFall;
  logic serWordAvail;
  logic [`NCO_WORD_W-1:0] serWord;
  logic busWordAvail;
  logic newAvail;
  logic [`NCO_WORD_W-1:0] newWord;
  nco_pkg::load_t applyLd;
  nco_pkg::sel_t pinSel;
  nco_pkg::sel_t srcPins;
  nco_pkg::sel_t effSel;
  logic [`NCO_ACC_W-1:0] curFreq;
  logic [`NCO_PH_W-1:0] curPhase;
  logic [`NCO_ACC_W-1:0] accNext;
  logic [`NCO_PH_W-1:0] phaseSum;

  // ****************************************
  // serial word capture
  // ****************************************
  // the shift clock is only sampled, so idle level does not matter; a fall
  // is seen as high then low on two sys_clk samples
  assign sclkFall = st_q.sclkPrev && !serialShiftClock && !word_frame_n
    && (st_q.bitCnt < `NCO_WORD_BITS);
  assign serWord = {st_q.shiftReg[`NCO_WORD_W-2:0], serial_data_in};
  assign serWordAvail = sclkFall && (st_q.bitCnt == `NCO_LAST_BIT);

  // a bus write to the command offset is refused in the cycle a serial word lands
  assign busWordAvail = regWr && (regAddr == `NCO_REG_CMD) && !serWordAvail;
  assign newAvail = serWordAvail || busWordAvail;
  assign newWord = serWordAvail ? serWord : regWrData[`NCO_WORD_W-1:0];

  // ****************************************
  // load path and register selection
  // ****************************************
  // with resampling off a word applies at the edge that completes it; with it
  // on, both the word and the pin selection pass two more flops, trading
  // latency for a load that never sees a half-changed word
  // the select bits only take effect once the source bit points at them, so
  // software can prepare them while the pins still steer the output
  assign applyLd = st_q.sync ? st_q.ld1 : nco_pkg::load_t'({newAvail, newWord});
  assign pinSel = nco_pkg::sel_t'({frequency_register_select, phase_register_select_hi,
    phase_register_select_lo});
  assign srcPins = st_q.sync ? st_q.selPipe1 : pinSel;
  assign effSel = st_q.select_source_bit ? st_q.selBits : srcPins;
  assign curFreq = st_q.freq[effSel.fsel];
  assign curPhase = st_q.phase[effSel.psel];
  assign accNext = st_q.acc + curFreq;
  assign phaseSum = st_q.acc[`NCO_ACC_W-1:`NCO_ACC_W-`NCO_PH_W] + curPhase;

  always_comb
  begin
    st_d = st_q;
    st_d.sclkPrev = serialShiftClock;

    // frame high restarts the word; a byte pause with frame low just continues
    if (word_frame_n)
    begin
      st_d.bitCnt = 5'h00;
    end
    else if (sclkFall)
    begin
      st_d.bitCnt = st_q.bitCnt + 5'h01;
      st_d.shiftReg = serWord;
    end

    // the word resample pipe only fills while enabled, the pin pipe always; turning it off drops a pending word
    st_d.ld0 = nco_pkg::load_t'({newAvail && st_q.sync, newWord});
    st_d.ld1 = st_q.sync ? st_q.ld0 : nco_pkg::load_t'('0);
    st_d.selPipe0 = pinSel;
    st_d.selPipe1 = st_q.selPipe0;

    st_d.clr = 1'b0;
    if (st_q.clr)
    begin
      st_d.sync = 1'b0;
      st_d.select_source_bit = 1'b0;
    end

    if (applyLd.valid)
    begin
      case (applyLd.word[15:14])
        `NCO_CTRL_SYNCSEL:
        begin
          st_d.sync = applyLd.word[`NCO_BIT_SYNC];
          st_d.select_source_bit = applyLd.word[`NCO_BIT_SELECT_SOURCE_BIT];
        end
        `NCO_CTRL_PWRCLR:
        begin
          st_d.sleep = applyLd.word[`NCO_BIT_SLEEP];
          st_d.resetBit = applyLd.word[`NCO_BIT_RESET];
          st_d.clr = applyLd.word[`NCO_BIT_CLR];
        end
        default:
        begin
          case (applyLd.word[15:12])
            `NCO_CMD_DEST:
            begin
              // address nibble: 0-7 frequency bytes, 8-15 phase bytes
              if (!applyLd.word[11])
              begin
                st_d.freq[applyLd.word[10]][{applyLd.word[9:8], 3'h0} +: 8] =
                  applyLd.word[7:0];
              end
              else if (applyLd.word[8])
              begin
                st_d.phase[applyLd.word[10:9]][`NCO_PH_W-1:8] = applyLd.word[3:0];
              end
              else
              begin
                st_d.phase[applyLd.word[10:9]][7:0] = applyLd.word[7:0];
              end
            end
            `NCO_CMD_SELBITS:
            begin
              st_d.selBits = nco_pkg::sel_t'({applyLd.word[`NCO_BIT_FSEL],
                applyLd.word[`NCO_BIT_PSEL_HI], applyLd.word[`NCO_BIT_PSEL_LO]});
            end
            default:
            begin
              st_d.selBits = st_q.selBits;
            end
          endcase
        end
      endcase
    end

    // ****************************************
    // phase accumulator and output pipe
    // ****************************************
    // sleep freezes the accumulator instead of clearing it
    if (st_q.resetBit)
    begin
      st_d.acc = '0;
    end
    else if (!st_q.sleep)
    begin
      st_d.acc = accNext;
    end
    st_d.runPipe = {st_q.runPipe[`NCO_RUN_LAT-2:0], !st_q.resetBit};
    st_d.addrPipe = {st_q.addrPipe[`NCO_RUN_LAT-2:0], phaseSum};

    // ****************************************
    // register port read
    // ****************************************
    // read data stand for one cycle only and are zero otherwise, so a bus
    // that ors several slaves together needs no select of its own
    // the status word shows the effective selection, pins or bits, which is
    // what actually steers the accumulator and the phase offset at that moment
    st_d.rdData = 32'h0000_0000;
    if (regRd)
    begin
      case (regAddr)
        `NCO_REG_STATUS:
        begin
          st_d.rdData[`NCO_ST_RESET] = st_q.resetBit;
          st_d.rdData[`NCO_ST_SLEEP] = st_q.sleep;
          st_d.rdData[`NCO_ST_SYNC] = st_q.sync;
          st_d.rdData[`NCO_ST_SELECT_SOURCE_BIT] = st_q.select_source_bit;
          st_d.rdData[`NCO_ST_FSEL] = effSel.fsel;
          st_d.rdData[`NCO_ST_PSEL +: 2] = effSel.psel;
          st_d.rdData[`NCO_ST_BITCNT +: 5] = st_q.bitCnt;
        end
        `NCO_REG_PHASE:
        begin
          st_d.rdData = st_q.acc;
        end
        default:
        begin
          st_d.rdData = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_q <= '0;
      st_q.resetBit <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign regRdData = st_q.rdData;
  assign waveAddr = st_q.addrPipe[`NCO_RUN_LAT-1];
  assign waveActive = st_q.runPipe[`NCO_RUN_LAT-1];
  assign sleepMode = st_q.sleep;

  // ****************************************
  // assertions
  // ****************************************
  // all checks belong to the one clock and are off while reset is held
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence relStart;
    $fell(st_q.resetBit);
  endsequence

  sequence relHold;
    (!st_q.resetBit)[*6];
  endsequence

  // the reverse path: output must stop once the reset bit is set again
  sequence resetRaise;
    $rose(st_q.resetBit);
  endsequence

  sequence resetHold;
    st_q.resetBit[*6];
  endsequence

  a_reset_holds_acc:
  assert property (st_q.resetBit |=> (st_q.acc == '0))
    else $error("accumulator not held at zero");

  a_clear_forces_off:
  assert property ((st_q.clr && !applyLd.valid) |=> (!st_q.sync && !st_q.select_source_bit))
    else $error("clear did not turn off resample and source");

  a_clear_self_ends:
  assert property (st_q.clr |=> !st_q.clr)
    else $error("clear bit did not return to zero");

  a_run_latency:
  assert property ((relStart ##0 relHold) |=> (waveActive && !$past(waveActive)))
    else $error("output not started six cycles after release");

  a_freq_step:
  assert property ((!st_q.resetBit && !st_q.sleep) |=> (st_q.acc == $past(accNext)))
    else $error("accumulator step is not the selected word");

  a_phase_offset:
  assert property (1'b1 ##6 1'b1 |-> (waveAddr == $past(phaseSum, 6)))
    else $error("output phase does not include the offset");

  a_pin_select:
  assert property ((!st_q.select_source_bit && !st_q.sync) |-> (effSel == pinSel))
    else $error("selection does not follow the pins");

  a_word_after_16:
  assert property (serWordAvail |-> (st_q.bitCnt == `NCO_LAST_BIT) && !word_frame_n)
    else $error("word transferred before sixteenth edge");

  a_sync_delay:
  assert property ((newAvail && st_q.sync && $stable(st_q.sync)) ##1 st_q.sync |-> ##1
    (st_q.ld1.valid && applyLd.valid))
    else $error("resampled load not two cycles late");

  a_ignore_extra:
  assert property ((st_q.bitCnt == `NCO_WORD_BITS && !word_frame_n) |=> (st_q.bitCnt == `NCO_WORD_BITS))
    else $error("edge after sixteen bits was taken");

  a_run_stops:
  assert property ((resetRaise ##0 resetHold) |=> !waveActive)
    else $error("output still active six cycles after reset bit set");

  a_sleep_freezes:
  assert property ((st_q.sleep && !st_q.resetBit) |=> (st_q.acc == $past(st_q.acc)))
    else $error("accumulator moved while asleep");

  a_reset_keeps_words:
  assert property ((st_q.resetBit && !applyLd.valid) |=> ($stable(st_q.freq) && $stable(st_q.phase)))
    else $error("reset bit altered frequency or phase words");

  a_bit_select:
  assert property (st_q.select_source_bit |-> (effSel == st_q.selBits))
    else $error("selection does not follow the select bits");

  a_pin_sync_delay:
  assert property ((!st_q.select_source_bit && st_q.sync) |-> (effSel == $past(pinSel, 2)))
    else $error("resampled pin selection not two cycles late");

  a_frame_restart:
  assert property (word_frame_n |=> (st_q.bitCnt == 5'h00))
    else $error("frame high did not restart the word");

  a_shift_msb:
  assert property (sclkFall |=> (st_q.shiftReg[0] == $past(serial_data_in)))
    else $error("sampled bit not shifted in at the bottom");

  a_count_step:
  assert property (sclkFall |=> (st_q.bitCnt == $past(st_q.bitCnt) + 5'h01))
    else $error("falling edge did not count one bit");

  a_no_fall_hold:
  assert property ((!sclkFall && !word_frame_n) |=> $stable(st_q.bitCnt))
    else $error("bit counted without a falling edge");

  a_status_read:
  assert property ((regRd && regAddr == `NCO_REG_STATUS) |=> (regRdData[`NCO_ST_RESET] == $past(st_q.resetBit)))
    else $error("status read does not show the reset bit");

endmodule

// ==== sim/nco_serial_host.sv ====
// host model driving the framed serial word port
`timescale 1ns/10ps

module nco_serial_host
(
  input wire logic sys_clk,
  output logic word_frame_n,
  output logic serialShiftClock,
  output logic serial_data_in
);
  initial
  begin
    word_frame_n = 1'h1;
    serialShiftClock = 1'h1;
    serial_data_in = 1'h0;
  end

  // ****
  // sends w[n-1] down to w[0]; idle is the shift clock level outside the frame
  // ****
  task automatic send(input logic [31:0] w, input int n, input logic idle, input logic endFrame);
    int i;
    // clock reaches idle before the frame falls, so no stray fall is counted;
    // inside an open frame the clock stays high, a fall there would be a bit
    @(posedge sys_clk);
    if (word_frame_n)
      serialShiftClock <= idle;
    @(posedge sys_clk);
    word_frame_n <= 1'h0;
    for (i = n - 1; i >= 0; i--)
    begin
      serialShiftClock <= 1'h1;
      serial_data_in <= w[i];
      repeat (2) @(posedge sys_clk);
      serialShiftClock <= 1'h0;
      repeat (3) @(posedge sys_clk);
    end
    serialShiftClock <= endFrame ? idle : 1'h1;
    serial_data_in <= ~w[0];
    @(posedge sys_clk);
    if (endFrame)
      word_frame_n <= 1'h1;
    @(posedge sys_clk);
  endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the oscillator control block
`timescale 1ns/10ps
`include "nco_cfg.svh"

module tb;
  logic sys_clk;
  logic reset;
  logic [7:0] regAddr;
  logic [31:0] regWrData;
  logic regWr;
  logic regRd;
  logic [31:0] regRdData;
  logic frameN;
  logic shiftClk;
  logic dataIn;
  logic fselPin;
  logic [1:0] pselPin;
  logic [11:0] waveAddr;
  logic waveActive;
  logic sleepMode;
  logic [31:0] freq0;
  logic [11:0] phase [4];
  logic [31:0] rd;
  logic [31:0] rd2;
  logic [1:0] ps;
  int errTotal;
  int nTests;
  int p;

  nco_serial_load_and_init nco_serial_load_and_init_i (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .word_frame_n(frameN),
    .serialShiftClock(shiftClk), .serial_data_in(dataIn), .frequency_register_select(fselPin),
    .phase_register_select_lo(pselPin[0]), .phase_register_select_hi(pselPin[1]), .waveAddr(waveAddr),
    .waveActive(waveActive), .sleepMode(sleepMode));

  nco_serial_host nco_serial_host_i (.sys_clk(sys_clk), .word_frame_n(frameN), .serialShiftClock(shiftClk),
    .serial_data_in(dataIn));

  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****
  // bus and compare helpers
  // ****
  task automatic finishTest;
    if (errTotal == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic regWrite(input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= `NCO_REG_CMD;
    regWrData <= {16'h0000, d};
    regWr <= 1'h1;
    @(posedge sys_clk);
    regWr <= 1'h0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1 d = regRdData;
  endtask

  // two accumulator reads ten cycles apart
  task automatic accDelta(output logic [31:0] d);
    regRead(`NCO_REG_PHASE, rd);
    repeat (8) @(posedge sys_clk);
    regRead(`NCO_REG_PHASE, rd2);
    d = rd2 - rd;
  endtask

  task automatic ser(input logic [31:0] w, input int n, input logic endFrame);
    nco_serial_host_i.send(w, n, 1'($urandom), endFrame);
  endtask

  // destination loads go as two bytes under one frame
  task automatic loadByte(input int a, input logic [7:0] b);
    ser({28'h0000003, 4'(a)}, 8, 1'h0);
    ser({24'h000000, b}, 8, 1'h1);
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    errTotal++;
    finishTest();
  end

  initial
  begin
    {regAddr, regWrData, regWr, regRd, fselPin, pselPin} = '0;
    reset = 1'h1;
    errTotal = 0;
    nTests = 0;
    void'($urandom(19));
    repeat (3) @(posedge sys_clk);
    reset <= 1'h0;
    regRead(`NCO_REG_STATUS, rd);
    chk(rd, 32'h00000001);
    regRead(8'h0C, rd);
    chk(rd, 32'h00000000);
    chk({30'h0, sleepMode, waveActive}, 32'h00000000);
    freq0 = $urandom;
    for (p = 0; p < 4; p++)
      phase[p] = 12'($urandom);
    for (p = 0; p < 8; p++)
      loadByte(p, (p < 4) ? freq0[8*p +: 8] : 8'h00);
    for (p = 0; p < 4; p++)
    begin
      loadByte(8 + 2 * p, phase[p][7:0]);
      loadByte(9 + 2 * p, {4'h0, phase[p][11:8]});
    end
    regRead(`NCO_REG_PHASE, rd);
    chk(rd, 32'h00000000);
    regWrite(16'hC000);
    repeat (5) @(posedge sys_clk);
    #1 chk({31'h0, waveActive}, 32'h00000000);
    @(posedge sys_clk);
    #1 chk({31'h0, waveActive}, 32'h00000001);
    accDelta(rd2);
    chk(rd2, freq0 * 32'h0000000A);
    @(posedge sys_clk);
    fselPin <= 1'h1;
    accDelta(rd2);
    chk(rd2, 32'h00000000);
    regRead(`NCO_REG_PHASE, rd);
    for (p = 0; p < 4; p++)
    begin
      @(posedge sys_clk);
      pselPin <= 2'(p);
      repeat (8) @(posedge sys_clk);
      #1 chk({20'h0, waveAddr}, {20'h0, rd[31:20] + phase[p]});
    end
    ps = 2'($urandom);
    ser(32'h00009000, 16, 1'h1);
    ser({12'h000, 4'h1, 1'h0, ps, 9'h000, 4'hF}, 20, 1'h1);
    regRead(`NCO_REG_STATUS, rd);
    chk(rd & 32'h0000007F, {25'h0, ps, 1'h0, 1'h1, 3'h0});
    accDelta(rd2);
    chk(rd2, freq0 * 32'h0000000A);
    ser(32'h0000B000, 16, 1'h1);
    ser(32'h000000C8, 8, 1'h0);
    regRead(`NCO_REG_STATUS, rd);
    chk(rd & 32'h00000F8C, 32'h0000040C);
    ser(32'h00000000, 8, 1'h1);
    regRead(`NCO_REG_STATUS, rd);
    chk(rd & 32'h0000000F, 32'h00000000);
    accDelta(rd2);
    chk(rd2, 32'h00000000);
    ser(32'h0000D000, 16, 1'h1);
    regRead(`NCO_REG_PHASE, rd);
    chk(rd, 32'h00000000);
    repeat (6) @(posedge sys_clk);
    #1 chk({31'h0, waveActive}, 32'h00000000);
    @(posedge sys_clk);
    fselPin <= 1'h0;
    regWrite(16'hC000);
    accDelta(rd2);
    chk(rd2, freq0 * 32'h0000000A);
    regWrite(16'hE000);
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, sleepMode}, 32'h00000001);
    finishTest();
  end
endmodule
